// File: include/led_i2c_pkg.sv
package led_i2c_pkg;

  // Register offsets
  localparam logic [7:0] OFS_POWER       = 8'h00;
  localparam logic [7:0] OFS_DUTY_FIRST  = 8'h07;
  localparam logic [7:0] OFS_DUTY_LAST   = 8'h1e;
  localparam logic [7:0] OFS_UPDATE      = 8'h49;
  localparam logic [7:0] OFS_SCALE_FIRST = 8'h4d;
  localparam logic [7:0] OFS_SCALE_LAST  = 8'h58;
  localparam logic [7:0] OFS_GLOBAL      = 8'h6e;
  localparam logic [7:0] OFS_PHASE       = 8'h70;
  localparam logic [7:0] OFS_OSD_EN      = 8'h71;
  localparam logic [7:0] OFS_OS_STAT_LO  = 8'h72;
  localparam logic [7:0] OFS_OS_STAT_HI  = 8'h73;
  localparam logic [7:0] OFS_TEMP        = 8'h77;
  localparam logic [7:0] OFS_SPREAD      = 8'h78;
  localparam logic [7:0] OFS_RESET       = 8'h7f;

  // Sizes
  localparam int DUTY_BYTES = 24;
  localparam int CHANNELS   = 12;
  localparam int BYTE_W     = 8;

  // Values
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] UPDATE_KEY    = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int         SOFT_OFF_BIT  = 0;

  // Target address
  localparam logic [4:0] ADDR_FIXED = 5'h0d;
  localparam logic [1:0] STRAP_GND  = 2'h0;
  localparam logic [1:0] STRAP_SCL  = 2'h1;
  localparam logic [1:0] STRAP_SDA  = 2'h2;
  localparam logic [3:0] BITS_FULL  = 4'h8;
  localparam logic [3:0] BITS_LAST  = 4'h7;
  localparam logic       RW_READ    = 1'b1;

  // Link state machine
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_RECV = 6'b001000,
    ST_SEND = 6'b010000,
    ST_MACK = 6'b100000
  } link_state_t;

endpackage

// File: rtl/led_i2c_target.sv
`timescale 1ns/10ps
module led_i2c_target
  import led_i2c_pkg::*;
(
  input  wire logic          mclk_in,
  input  wire logic          nrst_in,
  input  wire logic          ce_in,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  input  wire logic          ad_strap_in,
  input  wire logic          hw_shutdown_pin_in,
  output logic               sda_out,
  output logic               sda_oe_out,
  output logic [191:0]       pwm_duty_out,
  output logic [95:0]        channel_current_scale_out,
  output logic [7:0]         global_current_gain_out,
  output logic [7:0]         power_control_out,
  output logic [7:0]         phase_delay_out,
  output logic [7:0]         osd_enable_out,
  output logic [7:0]         spread_spectrum_out,
  output logic               device_active_out
);

  // ---------------- Link side (clocked by mclk, SCL edges detected) ----------------
  // The link logic runs on mclk: detected SCL rising edges sample, falling edges drive.
  // START/STOP are seen on SDA edges with SCL high, caught in mclk domain.

  logic [2:0]  mclk_pins;      // {ad, sda, scl} filtered in mclk domain
  logic        scl_f;
  logic        sda_f;
  logic        ad_f;
  logic        scl_d;
  logic        sda_d;
  logic        start_ev;
  logic        stop_ev;
  logic        scl_rise;
  logic        scl_fall;

  link_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic        rw_bit;
  logic        first_byte;
  logic [7:0]  ptr;
  logic        ad_all_high;
  logic        ad_eq_sda;
  logic [1:0]  strap_bits;
  logic        addr_match;
  logic        load_send;

  logic        wr_tog;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        rd_tog;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        ans_tog;

  // Pins pass four flops (three sync stages plus filter) into the engine clock
  tri_sync #(.WIDTH(3)) pin_sync (
    .clk_in   (mclk_in),
    .async_in ({ad_strap_in, sda_in, scl_in}),
    .filt_out (mclk_pins)
  );

  assign scl_f = mclk_pins[0];
  assign sda_f = mclk_pins[1];
  assign ad_f  = mclk_pins[2];

  // Previous filtered levels for edge detection
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_in) begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_ev  = scl_f & scl_d & ~sda_d & sda_f;

  always_comb begin
    if (ad_all_high) begin
      strap_bits = STRAP_SCL;
    end else if (ad_eq_sda) begin
      strap_bits = STRAP_SDA;
    end else begin
      strap_bits = STRAP_GND;
    end
  end

  assign addr_match = (shift[7:3] == ADDR_FIXED) && (shift[2:1] == strap_bits);

  // First read byte after address ack, or next byte after controller ack
  assign load_send = scl_fall && ((state == ST_ACK && rw_bit == RW_READ) || state == ST_MACK);

  // Strap tracking over the address bits
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || (ce_in && start_ev)) begin
      ad_all_high <= 1'b1;
      ad_eq_sda   <= 1'b1;
    end else if (ce_in && state == ST_ADDR && scl_rise) begin
      ad_all_high <= ad_all_high & ad_f;
      ad_eq_sda   <= ad_eq_sda & (ad_f == sda_f);
    end
  end

  // Byte engine and state machine
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state      <= ST_IDLE;
      bit_cnt    <= '0;
      shift      <= '0;
      rw_bit     <= 1'b0;
      first_byte <= 1'b0;
    end else if (ce_in) begin
      if (start_ev) begin
        state   <= ST_ADDR;
        bit_cnt <= '0;
      end else if (stop_ev) begin
        state <= ST_IDLE;
      end else begin
        unique case (state)
          ST_IDLE: begin
            bit_cnt <= '0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_FULL) begin
              state      <= addr_match ? ST_ACK : ST_IDLE;
              rw_bit     <= shift[0];
              first_byte <= 1'b1;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= '0;
              if (rw_bit == RW_READ) begin
                state <= ST_SEND;
                shift <= rd_data;
              end else begin
                state <= ST_RECV;
              end
            end
          end
          ST_RECV: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_FULL) begin
              state      <= ST_ACK;
              first_byte <= 1'b0;
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt == BITS_LAST) begin
                state <= ST_MACK;
              end else begin
                shift   <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise && sda_f) begin
              // Controller not-ack: wait for STOP
              state <= ST_IDLE;
            end else if (scl_fall) begin
              state   <= ST_SEND;
              shift   <= rd_data;
              bit_cnt <= '0;
            end
          end
        endcase
      end
    end
  end

  // drive SDA only for ack and read data
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (ce_in) begin
      sda_out <= 1'b0;
      if (start_ev || stop_ev) begin
        sda_oe_out <= 1'b0;
      end else if (scl_fall) begin
        unique case (state)
          ST_ADDR: sda_oe_out <= (bit_cnt == BITS_FULL) && addr_match;
          ST_RECV: sda_oe_out <= (bit_cnt == BITS_FULL);
          ST_ACK:  sda_oe_out <= (rw_bit == RW_READ) && !rd_data[7];
          ST_SEND: sda_oe_out <= (bit_cnt != BITS_LAST) && !shift[6];
          ST_MACK: sda_oe_out <= !rd_data[7];
          ST_IDLE: sda_oe_out <= 1'b0;
        endcase
      end
    end
  end

  // Register pointer and read prefetch
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ptr     <= '0;
      rd_addr <= '0;
      rd_tog  <= 1'b0;
    end else if (ce_in) begin
      if (state == ST_ADDR && scl_fall && bit_cnt == BITS_FULL && addr_match && shift[0] == RW_READ) begin
        rd_addr <= ptr;
        rd_tog  <= ~rd_tog;
      end else if (state == ST_RECV && scl_fall && bit_cnt == BITS_FULL) begin
        if (first_byte) begin
          ptr <= shift;
        end else begin
          ptr <= ptr + 8'h01;
        end
      end else if (load_send) begin
        ptr     <= ptr + 8'h01;
        rd_addr <= ptr + 8'h01;
        rd_tog  <= ~rd_tog;
      end
    end
  end

  // Write request to register file
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      wr_tog  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else if (ce_in && state == ST_RECV && scl_fall && bit_cnt == BITS_FULL && !first_byte) begin
      wr_addr <= ptr;
      wr_data <= shift;
      wr_tog  <= ~wr_tog;
    end
  end

  // ---------------- Register file ----------------
  logic        wr_seen;
  logic        rd_seen;
  logic        wr_ev;
  logic        rd_ev;
  logic        hw_sd_f;
  logic        soft_clear;
  logic        update_go;
  logic [7:0]  duty_pend [DUTY_BYTES];
  logic [7:0]  os_stat_lo;
  logic [7:0]  os_stat_hi;
  logic [7:0]  temp_info;
  logic [7:0]  duty_idx;
  logic [7:0]  scale_idx;
  logic [7:0]  next_rd_data;
  logic [7:0]  rd_duty_idx;
  logic [7:0]  rd_scale_idx;

  // Shutdown pin into mclk domain
  tri_sync #(.WIDTH(1)) sdb_sync (
    .clk_in   (mclk_in),
    .async_in (hw_shutdown_pin_in),
    .filt_out (hw_sd_f)
  );

  assign wr_ev     = wr_tog ^ wr_seen;
  assign rd_ev     = rd_tog ^ rd_seen;
  assign duty_idx  = wr_addr - OFS_DUTY_FIRST;
  assign scale_idx = wr_addr - OFS_SCALE_FIRST;
  assign soft_clear = wr_ev && wr_addr == OFS_RESET;
  assign update_go  = wr_ev && wr_addr == OFS_UPDATE && wr_data == UPDATE_KEY
                      && hw_sd_f && power_control_out[SOFT_OFF_BIT];

  // Request bookkeeping
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
    end else if (ce_in) begin
      wr_seen <= wr_tog;
      rd_seen <= rd_tog;
    end
  end

  // Pending duty bytes
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || (ce_in && soft_clear)) begin
      for (int i = 0; i < DUTY_BYTES; i++) begin
        duty_pend[i] <= REG_RESET_VAL;
      end
    end else if (ce_in && wr_ev && wr_addr >= OFS_DUTY_FIRST && wr_addr <= OFS_DUTY_LAST) begin
      duty_pend[duty_idx[4:0]] <= wr_data;
    end
  end

  // Active duty values for the PWM core
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || (ce_in && soft_clear)) begin
      pwm_duty_out <= '0;
    end else if (ce_in && update_go) begin
      for (int i = 0; i < DUTY_BYTES; i++) begin
        pwm_duty_out[i*BYTE_W +: BYTE_W] <= duty_pend[i];
      end
    end
  end

  // Scaling, global gain and control bytes
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || (ce_in && soft_clear)) begin
      channel_current_scale_out <= '0;
      global_current_gain_out   <= REG_RESET_VAL;
      power_control_out         <= REG_RESET_VAL;
      phase_delay_out           <= REG_RESET_VAL;
      osd_enable_out            <= REG_RESET_VAL;
      spread_spectrum_out       <= REG_RESET_VAL;
      os_stat_lo                <= REG_RESET_VAL;
      os_stat_hi                <= REG_RESET_VAL;
      temp_info                 <= REG_RESET_VAL;
    end else if (ce_in && wr_ev) begin
      if (wr_addr >= OFS_SCALE_FIRST && wr_addr <= OFS_SCALE_LAST) begin
        channel_current_scale_out[scale_idx[3:0]*BYTE_W +: BYTE_W] <= wr_data;
      end
      unique case (wr_addr)
        OFS_POWER:      power_control_out       <= wr_data;
        OFS_GLOBAL:     global_current_gain_out <= wr_data;
        OFS_PHASE:      phase_delay_out         <= wr_data;
        OFS_OSD_EN:     osd_enable_out          <= wr_data;
        OFS_SPREAD:     spread_spectrum_out     <= wr_data;
        OFS_OS_STAT_LO: os_stat_lo              <= wr_data;
        OFS_OS_STAT_HI: os_stat_hi              <= wr_data;
        OFS_TEMP:       temp_info               <= wr_data;
        default: ;
      endcase
    end
  end

  // run only when pin high and bit set
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      device_active_out <= 1'b0;
    end else if (ce_in) begin
      device_active_out <= hw_sd_f && power_control_out[SOFT_OFF_BIT];
    end
  end

  assign rd_duty_idx  = rd_addr - OFS_DUTY_FIRST;
  assign rd_scale_idx = rd_addr - OFS_SCALE_FIRST;

  // read mux; write-only and unmapped read zero
  always_comb begin
    next_rd_data = READ_UNMAPPED;
    if (rd_addr >= OFS_DUTY_FIRST && rd_addr <= OFS_DUTY_LAST) begin
      next_rd_data = duty_pend[rd_duty_idx[4:0]];
    end else if (rd_addr >= OFS_SCALE_FIRST && rd_addr <= OFS_SCALE_LAST) begin
      next_rd_data = channel_current_scale_out[rd_scale_idx[3:0]*BYTE_W +: BYTE_W];
    end else begin
      unique case (rd_addr)
        OFS_POWER:      next_rd_data = power_control_out;
        OFS_GLOBAL:     next_rd_data = global_current_gain_out;
        OFS_PHASE:      next_rd_data = phase_delay_out;
        OFS_OSD_EN:     next_rd_data = osd_enable_out;
        OFS_SPREAD:     next_rd_data = spread_spectrum_out;
        OFS_OS_STAT_LO: next_rd_data = os_stat_lo;
        OFS_OS_STAT_HI: next_rd_data = os_stat_hi;
        OFS_TEMP:       next_rd_data = temp_info;
        default:        next_rd_data = READ_UNMAPPED;
      endcase
    end
  end

  // Read answer latched for the link engine
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rd_data <= READ_UNMAPPED;
      ans_tog <= 1'b0;
    end else if (ce_in && rd_ev) begin
      rd_data <= next_rd_data;
      ans_tog <= ~ans_tog;
    end
  end

endmodule

// File: rtl/tri_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser with agreement filter
module tri_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] filt_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    stage1 <= async_in;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // A bit changes once stages two and three agree
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        filt_out[i] <= stage3[i];
      end
    end
  end

endmodule

// File: tb/i2c_ctrl_model.sv
`timescale 1ns/10ps
module i2c_ctrl_model #(
  parameter int HALF = 70
) (
  input  wire logic link_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      pull_out
);
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_in);
  endtask
  task automatic bit_x(input logic b, output logic r);
    tick(8);
    pull_out <= !b;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF / 2);
    r = sda_in;
    tick(HALF / 2);
    scl_out <= 1'b0;
  endtask
  task automatic start();
    tick(8);
    pull_out <= 1'b0;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    pull_out <= 1'b1;
    tick(HALF);
    scl_out <= 1'b0;
  endtask
  // stop ends frame, clock parks high
  task automatic stop();
    tick(8);
    pull_out <= 1'b1;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    pull_out <= 1'b0;
    tick(HALF);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  // byte in, then ack or nack
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// File: tb/led_driver_i2c_register_port_test.sv
`timescale 1ns/10ps
module led_driver_i2c_register_port_test
  import led_i2c_pkg::*;
();
  logic         mclk_in, link_clk, nrst_in, ce_in, hw_pin, d_sda, d_oe, act, a;
  logic [1:0]   strap;
  logic [191:0] pwm, ed;
  logic [95:0]  scale, es;
  logic [7:0]   gain, pc, ph, osd, ss;
  logic [7:0]   q[$], dd[$], sd[$];
  wire          scl_w, m_pull, sda_w, ad_w;
  int           fail_count, samples_checked;
  // Open-drain wire with pull-up, strap wiring
  assign sda_w = (d_oe ? d_sda : 1'b1) & !m_pull;
  assign ad_w = (strap == 2'h1) ? scl_w : (strap == 2'h2) ? sda_w : 1'b0;
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  i2c_ctrl_model ctrl (.link_clk_in(link_clk), .sda_in(sda_w), .scl_out(scl_w), .pull_out(m_pull));
  led_i2c_target dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in), .scl_in(scl_w), .sda_in(sda_w),
    .ad_strap_in(ad_w), .hw_shutdown_pin_in(hw_pin), .sda_out(d_sda), .sda_oe_out(d_oe),
    .pwm_duty_out(pwm), .channel_current_scale_out(scale), .global_current_gain_out(gain),
    .power_control_out(pc), .phase_delay_out(ph), .osd_enable_out(osd), .spread_spectrum_out(ss),
    .device_active_out(act));
  task automatic chk(input logic [191:0] got, input logic [191:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: %s", $time, m);
      fail_count++;
    end
  endtask
  function automatic logic [7:0] adr(input logic rw);
    return {5'b01101, strap, rw};
  endfunction
  // Write burst from a register offset
  task automatic wr(input logic [7:0] ra, input logic [7:0] d[$]);
    ctrl.start();
    ctrl.put(adr(1'b0), a);
    chk(a, 0, "address ack");
    ctrl.put(ra, a);
    chk(a, 0, "offset ack");
    foreach (d[i]) begin
      ctrl.put(d[i], a);
      chk(a, 0, "data ack");
    end
    ctrl.stop();
  endtask
  // Offset write, repeated start, read burst
  task automatic rd(input logic [7:0] ra, input int n);
    logic [7:0] b;
    q = {};
    ctrl.start();
    ctrl.put(adr(1'b0), a);
    chk(a, 0, "read setup address ack");
    ctrl.put(ra, a);
    chk(a, 0, "read pointer ack");
    ctrl.start();
    ctrl.put(adr(1'b1), a);
    chk(a, 0, "read address ack");
    for (int i = 0; i < n; i++) begin
      ctrl.get(i == n - 1, b);
      q.push_back(b);
    end
    ctrl.stop();
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #5000000;
    fail_count++;
    final_report;
  end
  // Main sequence
  initial begin
    fail_count = 0;
    samples_checked = 0;
    nrst_in = 1'b0;
    ce_in = 1'b1;
    hw_pin = 1'b1;
    strap = 2'h0;
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chk(pwm, 0, "reset duty");
    chk(scale, 0, "reset scaling");
    chk({gain, pc, ph, osd, ss, act}, 0, "reset bytes");
    $display("test reset done");
    for (int s = 0; s < 3; s++) begin
      @(posedge mclk_in) strap <= s[1:0];
      @(posedge mclk_in);
      wr(OFS_GLOBAL, {8'h5a ^ s[7:0]});
      chk(gain, 8'h5a ^ s[7:0], "global gain");
      rd(OFS_GLOBAL, 1);
      chk(q[0], 8'h5a ^ s[7:0], "global readback");
    end
    $display("test strap done");
    ctrl.start();
    ctrl.put({5'b01100, strap, 1'b0}, a);
    ctrl.stop();
    chk(a, 1, "foreign address acked");
    @(posedge mclk_in) ce_in <= 1'b0;
    ctrl.start();
    ctrl.put(adr(1'b0), a);
    ctrl.stop();
    chk(a, 1, "frozen engine acked");
    @(posedge mclk_in) ce_in <= 1'b1;
    $display("test foreign done");
    for (int k = 0; k < 12; k++) begin
      sd.push_back(8'h10 + k[7:0]);
      es[8*k+:8] = 8'h10 + k[7:0];
    end
    wr(OFS_SCALE_FIRST, sd);
    chk(scale, es, "scaling burst");
    rd(OFS_SCALE_FIRST, 12);
    foreach (q[k]) chk(q[k], 8'h10 + k[7:0], "scaling readback");
    $display("test scaling done");
    for (int k = 0; k < 24; k++) begin
      dd.push_back(8'h80 + k[7:0]);
      ed[8*k+:8] = 8'h80 + k[7:0];
    end
    wr(OFS_DUTY_FIRST, dd);
    chk(pwm, 0, "duty applied early");
    rd(8'h1d, 2);
    chk({q[0], q[1]}, 16'h9697, "duty readback");
    wr(OFS_UPDATE, {8'h00});
    chk(pwm, 0, "update with soft bit clear");
    wr(OFS_POWER, {8'h01});
    chk({pc, act}, 9'h003, "soft bit and active");
    wr(OFS_UPDATE, {8'h01});
    chk(pwm, 0, "update with nonzero key");
    @(posedge mclk_in) hw_pin <= 1'b0;
    wr(OFS_UPDATE, {8'h00});
    chk(pwm, 0, "update with pin low");
    chk(act, 0, "active with pin low");
    @(posedge mclk_in) hw_pin <= 1'b1;
    wr(OFS_UPDATE, {8'h00});
    chk(pwm, ed, "duty applied");
    chk(act, 1, "active with pin high");
    rd(OFS_UPDATE, 1);
    chk(q[0], 0, "update location read");
    $display("test update done");
    wr(OFS_PHASE, {8'h81});
    wr(OFS_OSD_EN, {8'h03});
    wr(OFS_SPREAD, {8'h55});
    chk({ph, osd, ss}, 24'h810355, "misc bytes");
    rd(OFS_PHASE, 2);
    chk({q[0], q[1]}, 16'h8103, "misc readback");
    wr(OFS_RESET, {8'ha5});
    @(posedge mclk_in);
    chk(pwm, 0, "soft reset duty");
    chk(scale, 0, "soft reset scaling");
    chk({gain, pc, ph, osd, ss, act}, 0, "soft reset bytes");
    rd(OFS_DUTY_FIRST, 1);
    chk(q[0], 0, "soft reset pending duty");
    $display("test soft reset done");
    final_report;
  end
endmodule

// File: tb/led_i2c_target_sva.sv
`timescale 1ns/10ps
module led_i2c_target_sva (
  input wire logic         mclk_in,
  input wire logic         nrst_in,
  input wire logic         scl_in,
  input wire logic         sda_in,
  input wire logic         hw_shutdown_pin_in,
  input wire logic         sda_out,
  input wire logic         sda_oe_out,
  input wire logic [191:0] pwm_duty_out,
  input wire logic [95:0]  channel_current_scale_out,
  input wire logic [7:0]   global_current_gain_out,
  input wire logic [7:0]   power_control_out,
  input wire logic         device_active_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // Pin only ever pulled low
  chk_oe_pulls_low: assert property (sda_oe_out |-> !sda_out)
    else $error("data pin driven high");
  // Drive starts only while clock is low
  chk_oe_rise_low: assert property ($rose(sda_oe_out) |-> !scl_in ##1 !scl_in)
    else $error("data drive began with clock high");
  // Drive steady while clock high
  chk_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data drive moved with clock high");
  // Active flag follows soft bit and the pin as seen through its four-flop filter
  property active_follows;
    $changed(device_active_out) |-> device_active_out ==
      ($past(power_control_out[0]) && $past(hw_shutdown_pin_in, 5));
  endproperty
  chk_active_lag: assert property (active_follows)
    else $error("active flag mismatch");
  // Applied duty moves only on permitted update or clear
  property duty_gated;
    $changed(pwm_duty_out) |-> pwm_duty_out == '0
      || ($past(power_control_out[0]) && $past(hw_shutdown_pin_in, 5));
  endproperty
  chk_duty_gate: assert property (duty_gated)
    else $error("duty applied while gated");
  // Stores happen during the acknowledge low phase
  chk_gain_store_low: assert property ($changed(global_current_gain_out) |-> !scl_in)
    else $error("gain stored with clock high");
  chk_scale_store_low: assert property ($changed(channel_current_scale_out) |-> !scl_in)
    else $error("scaling stored with clock high");
  // Stop leaves the data pin released
  chk_stop_release: assert property (scl_in && $rose(sda_in) |-> ##1 !sda_oe_out [*8])
    else $error("pin held after stop");
  cov_ack: cover property ($rose(sda_oe_out));
  cov_update: cover property ($changed(pwm_duty_out) && pwm_duty_out != '0);
  cov_active: cover property ($rose(device_active_out));
endmodule

bind led_i2c_target led_i2c_target_sva chk (.mclk_in(mclk_in), .nrst_in(nrst_in), .scl_in(scl_in),
  .sda_in(sda_in), .hw_shutdown_pin_in(hw_shutdown_pin_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .pwm_duty_out(pwm_duty_out), .channel_current_scale_out(channel_current_scale_out),
  .global_current_gain_out(global_current_gain_out), .power_control_out(power_control_out),
  .device_active_out(device_active_out));
